// file: flash_poll_params.svh
// Purpose: constants of the flash status poller: register map, field positions, timing
// Assumes: 20 MHz system clock
// Notes:   definitions only
`ifndef FLASH_POLL_PARAMS_SVH
`define FLASH_POLL_PARAMS_SVH

// register byte offsets on the apb side
`define FP_REG_CTRL     8'h00
`define FP_REG_ADDR     8'h04
`define FP_REG_EXPECT   8'h08
`define FP_REG_STATUS   8'h0C
`define FP_REG_DATA     8'h10

// control register fields
`define FP_CTRL_START   0
`define FP_CTRL_MODE    1
`define FP_CTRL_ABORT   2

// status register fields
`define FP_ST_BUSY      0
`define FP_ST_DONE      1
`define FP_ST_PASS      2
`define FP_ST_FAIL      3
`define FP_ST_RDYBSY    4
`define FP_ST_SECTOG    5
`define FP_ST_EWIN      6
`define FP_ST_TMO       7

// status bits inside the flash data word
`define FP_COMPLEMENT_POLL_BIT 7
`define FP_TOGGLE_ONE_BIT      6
`define FP_TIMEOUT_FAIL_BIT    5
`define FP_ERASE_WINDOW_BIT    3
`define FP_SECTOR_TOGGLE_BIT   2

// pin widths and the software reset command word
`define FP_ADDR_W       18
`define FP_DATA_W       16
`define FP_RESET_CMD    16'h00F0

// timing: figures in ns, counts derived from the clock period
`define FP_CLK_NS       50
`define FP_ACC_NS       90
`define FP_WP_NS        45
`define FP_ACC_CYC      ((`FP_ACC_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_WP_CYC       ((`FP_WP_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)

`endif

// file: flash_poll_pkg.sv
// Purpose: types shared by the flash status poller modules
// Assumes: nothing
// Notes:   numbers live in flash_poll_params.svh
package flash_poll_pkg;

  typedef enum logic {MODE_TOGGLE, MODE_COMPLEMENT} poll_mode_e;

  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_RECOVER} cycle_state_e;

  typedef enum logic [2:0] {P_IDLE, P_FIRST, P_NEXT, P_RECHECK, P_FINAL, P_RESET} poll_state_e;

endpackage : flash_poll_pkg

// file: flash_bus_cycle.sv
// Purpose: one read or write cycle on the parallel flash pins
// Assumes: device read access and write pulse times from the params header
// Notes:   each read is framed by both chip select and output strobe
`timescale 1ns/1ps
`default_nettype none
`include "flash_poll_params.svh"

module flash_bus_cycle
  import flash_poll_pkg::*;
(
  // clocking
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  // request side
  input  wire logic                    start,
  input  wire logic                    write,
  input  wire logic [`FP_ADDR_W-1:0]   addr,
  input  wire logic [`FP_DATA_W-1:0]   wdata,
  output logic                         done,
  output logic      [`FP_DATA_W-1:0]   rdata,
  // flash pins
  output logic                         chipSelectN,
  output logic                         outputStrobeN,
  output logic                         writeStrobeN,
  output logic      [`FP_ADDR_W-1:0]   flashAddr,
  output logic      [`FP_DATA_W-1:0]   flashDataOut,
  output logic                         flashDataOeN,
  input  wire logic [`FP_DATA_W-1:0]   flashDataIn
);

  cycle_state_e           state_q;
  logic [3:0]             cnt_q;
  logic                   write_q;
  logic                   lastStrobe;

  assign lastStrobe = (cnt_q == 4'h1);

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer: setup, strobe for the timed length, recover
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= CY_IDLE;
      cnt_q         <= 4'h0;
      write_q       <= 1'b0;
      done          <= 1'b0;
      rdata         <= '0;
      chipSelectN   <= 1'b1;
      outputStrobeN <= 1'b1;
      writeStrobeN  <= 1'b1;
      flashAddr     <= '0;
      flashDataOut  <= '0;
      flashDataOeN  <= 1'b1;
    end else if (ce) begin
      done <= 1'b0;
      unique case (state_q)
        CY_IDLE: begin
          if (start) begin
            write_q      <= write;
            flashAddr    <= addr;
            flashDataOut <= wdata;
            flashDataOeN <= ~write;   // drive data only for writes
            chipSelectN  <= 1'b0;
            state_q      <= CY_SETUP;
          end
        end
        CY_SETUP: begin
          outputStrobeN <= write_q;
          writeStrobeN  <= ~write_q;
          cnt_q   <= write_q ? 4'(`FP_WP_CYC) : 4'(`FP_ACC_CYC);
          state_q <= CY_STROBE;
        end
        CY_STROBE: begin
          if (lastStrobe) begin
            if (!write_q) begin
              rdata <= flashDataIn;  // sampled while strobe is still low
            end
            outputStrobeN <= 1'b1;
            writeStrobeN  <= 1'b1;   // rising edge: device status becomes valid
            state_q       <= CY_RECOVER;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        CY_RECOVER: begin
          // chip select goes high each cycle so either framing toggles the status
          chipSelectN  <= 1'b1;
          flashDataOeN <= 1'b1;
          done         <= 1'b1;
          state_q      <= CY_IDLE;
        end
      endcase
    end
  end

endmodule : flash_bus_cycle
`default_nettype wire

// file: flash_status_poller.sv
// Purpose: host-side poller of flash program/erase status, controlled over apb
// Assumes: software wrote the program or erase command sequence beforehand
// Notes:   one poll at a time; done/pass/fail stay until the next start
`timescale 1ns/1ps
`default_nettype none
`include "flash_poll_params.svh"

module flash_status_poller
  import flash_poll_pkg::*;
(
  // clocking
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // flash pins
  output logic                         chipSelectN,
  output logic                         outputStrobeN,
  output logic                         writeStrobeN,
  output logic      [`FP_ADDR_W-1:0]   flashAddr,
  output logic      [`FP_DATA_W-1:0]   flashDataOut,
  output logic                         flashDataOeN,
  input  wire logic [`FP_DATA_W-1:0]   flashDataIn,
  input  wire logic                    readyBusyN
);

  ////////////////////////////////////////////////////////////////////////////
  // completion test shared by the normal check and the recheck
  function automatic logic statusMet(input poll_mode_e             mode,
                                     input logic [`FP_DATA_W-1:0] cur,
                                     input logic [`FP_DATA_W-1:0] prev,
                                     input logic                  expect_bit);
    if (mode == MODE_TOGGLE) begin
      statusMet = (cur[`FP_TOGGLE_ONE_BIT] == prev[`FP_TOGGLE_ONE_BIT]);
    end else begin
      statusMet = (cur[`FP_COMPLEMENT_POLL_BIT] == expect_bit);
    end
  endfunction : statusMet

  poll_state_e               state_q;
  poll_mode_e                mode_q;
  logic [`FP_ADDR_W-1:0]     pollAddr_q;
  logic                      expect_q;
  logic [`FP_DATA_W-1:0]     prev_q;
  logic [`FP_DATA_W-1:0]     data_q;
  logic                      done_q;
  logic                      pass_q;
  logic                      fail_q;
  logic                      secTog_q;
  logic                      tmoSeen_q;
  logic                      inFlight_q;
  logic                      rdValid_q;
  logic [31:0]               rdMux;
  logic                      mapped;
  logic                      apbWrite;
  logic                      startReq;
  logic                      abortReq;
  logic                      cycStart;
  logic                      cycWrite;
  logic                      cycDone;
  logic [`FP_DATA_W-1:0]     cycRdata;
  logic                      met;
  logic                      tmo;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; one-cycle answer, read data captured the cycle before pready
  assign mapped   = (paddr == `FP_REG_CTRL) || (paddr == `FP_REG_ADDR) || (paddr == `FP_REG_EXPECT) ||
                    (paddr == `FP_REG_STATUS) || (paddr == `FP_REG_DATA);
  assign pready   = psel & penable & ce & rdValid_q;
  assign pslverr  = pready & ~mapped;
  assign apbWrite = pready & pwrite & mapped;
  assign startReq = apbWrite && (paddr == `FP_REG_CTRL) && pwdata[`FP_CTRL_START] && !inFlight_q;
  assign abortReq = apbWrite && (paddr == `FP_REG_CTRL) && pwdata[`FP_CTRL_ABORT];

  // status word; ready_busy_n taken as synchronous, shown raw
  assign rdMux = (paddr == `FP_REG_CTRL)   ? {31'h0000_0000, mode_q == MODE_COMPLEMENT} << `FP_CTRL_MODE :
                 (paddr == `FP_REG_ADDR)   ? 32'(pollAddr_q) :
                 (paddr == `FP_REG_EXPECT) ? {31'h0000_0000, expect_q} :
                 (paddr == `FP_REG_STATUS) ? 32'({tmoSeen_q, data_q[`FP_ERASE_WINDOW_BIT], secTog_q, readyBusyN,
                                                  fail_q, pass_q, done_q, state_q != P_IDLE}) :
                 (paddr == `FP_REG_DATA)   ? 32'(data_q) : 32'h0000_0000;

  // apb read capture and configuration writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata     <= 32'h0000_0000;
      rdValid_q  <= 1'b0;
      mode_q     <= MODE_TOGGLE;
      pollAddr_q <= '0;
      expect_q   <= 1'b0;
    end else if (ce) begin
      prdata    <= mapped ? rdMux : 32'h0000_0000;
      rdValid_q <= psel;
      if (apbWrite && paddr == `FP_REG_CTRL) begin
        mode_q <= pwdata[`FP_CTRL_MODE] ? MODE_COMPLEMENT : MODE_TOGGLE;
      end
      if (apbWrite && paddr == `FP_REG_ADDR) begin
        pollAddr_q <= pwdata[`FP_ADDR_W-1:0];   // program address or erasing sector
      end
      if (apbWrite && paddr == `FP_REG_EXPECT) begin
        expect_q <= pwdata[0];                   // true datum bit once done
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash cycle requests: reads at the poll address, the reset command on failure
  assign cycStart = (state_q != P_IDLE) && !inFlight_q && !startReq && !abortReq;
  assign cycWrite = (state_q == P_RESET);
  assign met      = statusMet(mode_q, cycRdata, prev_q, expect_q);
  assign tmo      = cycRdata[`FP_TIMEOUT_FAIL_BIT];   // operation over its limit

  flash_bus_cycle u_cycle (
    .clock         (clock),
    .rst_n         (rst_n),
    .ce            (ce),
    .start         (cycStart),
    .write         (cycWrite),
    .addr          (pollAddr_q),
    .wdata         (`FP_RESET_CMD),
    .done          (cycDone),
    .rdata         (cycRdata),
    .chipSelectN   (chipSelectN),
    .outputStrobeN (outputStrobeN),
    .writeStrobeN  (writeStrobeN),
    .flashAddr     (flashAddr),
    .flashDataOut  (flashDataOut),
    .flashDataOeN  (flashDataOeN),
    .flashDataIn   (flashDataIn)
  );

  // one cycle outstanding at a time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inFlight_q <= 1'b0;
    end else if (ce) begin
      inFlight_q <= cycStart | (inFlight_q & ~cycDone);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // poll sequencer; abort leaves polling, a new start begins from the top
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= P_IDLE;
      prev_q    <= '0;
      data_q    <= '0;
      done_q    <= 1'b0;
      pass_q    <= 1'b0;
      fail_q    <= 1'b0;
      secTog_q  <= 1'b0;
      tmoSeen_q <= 1'b0;
    end else if (ce) begin
      if (abortReq) begin
        state_q <= P_IDLE;
      end else if (startReq) begin
        // toggle mode always restarts with a fresh double read
        state_q   <= (mode_q == MODE_TOGGLE) ? P_FIRST : P_NEXT;
        done_q    <= 1'b0;
        pass_q    <= 1'b0;
        fail_q    <= 1'b0;
        secTog_q  <= 1'b0;
        tmoSeen_q <= 1'b0;
      end else if (cycDone) begin
        unique case (state_q)
          P_IDLE: begin
          end
          P_FIRST: begin
            prev_q  <= cycRdata;
            state_q <= P_NEXT;
          end
          P_NEXT: begin
            prev_q   <= cycRdata;
            data_q   <= cycRdata;
            // sector toggle shows a sector selected for erase
            secTog_q <= secTog_q | (cycRdata[`FP_SECTOR_TOGGLE_BIT] ^ prev_q[`FP_SECTOR_TOGGLE_BIT]);
            if (met) begin
              state_q <= P_FINAL;                // unchanged toggle or true datum
            end else if (tmo) begin
              tmoSeen_q <= 1'b1;
              state_q   <= P_RECHECK;            // bit may settle with the timeout
            end
          end
          P_RECHECK: begin
            data_q  <= cycRdata;
            state_q <= met ? P_FINAL : P_RESET;  // still busy: send reset command
          end
          P_FINAL: begin
            // an extra read: the early-flipped bit may still sit beside stale bits
            data_q  <= cycRdata;
            pass_q  <= 1'b1;
            done_q  <= 1'b1;
            state_q <= P_IDLE;
          end
          P_RESET: begin
            fail_q  <= 1'b1;
            done_q  <= 1'b1;
            state_q <= P_IDLE;
          end
          default: begin
            state_q <= P_IDLE;
          end
        endcase
      end
    end
  end

endmodule : flash_status_poller
`default_nettype wire

// file: flash_status_poller_assertions.sv
// Purpose: pin and bus protocol checks for the flash status poller
// Assumes: ce held high by the bench
// Notes:   bound to every flash_status_poller instance
`timescale 1ns/1ps
`default_nettype none
`include "flash_poll_params.svh"

module flash_status_poller_assertions (
  // clocking
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic                  ce,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // flash pins
  input wire logic                  chipSelectN,
  input wire logic                  outputStrobeN,
  input wire logic                  writeStrobeN,
  input wire logic [`FP_ADDR_W-1:0] flashAddr,
  input wire logic [`FP_DATA_W-1:0] flashDataOut,
  input wire logic                  flashDataOeN,
  input wire logic [`FP_DATA_W-1:0] flashDataIn,
  input wire logic                  readyBusyN
);
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_apb_zero_wait: assert property (psel && penable && ce && $past(psel) |-> pready)
    else $error("pready missing in access phase");
  chk_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside a completing access");
  chk_strobe_in_cs: assert property (!outputStrobeN || !writeStrobeN |-> !chipSelectN)
    else $error("strobe active without chip select");
  chk_read_pulse_len: assert property ($fell(outputStrobeN) |-> ##1 !outputStrobeN ##1 outputStrobeN)
    else $error("output strobe not low for two cycles");
  chk_addr_held: assert property (!chipSelectN && $past(!chipSelectN) |-> $stable(flashAddr))
    else $error("flash address moved inside a cycle");
  chk_write_pulse: assert property ($fell(writeStrobeN) |=> writeStrobeN)
    else $error("write strobe not a single cycle");
  chk_no_bus_fight: assert property (!outputStrobeN |-> flashDataOeN)
    else $error("host drives data during a read");
  chk_reset_word: assert property (!writeStrobeN |-> !flashDataOeN && flashDataOut == `FP_RESET_CMD)
    else $error("write that is not the reset command");

  // main scenarios
  cover property ($fell(writeStrobeN));
  cover property (pslverr);
  cover property ($fell(outputStrobeN));
endmodule : flash_status_poller_assertions

bind flash_status_poller flash_status_poller_assertions u_chk (
  .clock, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .chipSelectN, .outputStrobeN, .writeStrobeN, .flashAddr, .flashDataOut, .flashDataOeN,
  .flashDataIn, .readyBusyN);
`default_nettype wire

// file: flash_dev_model.sv
// Purpose: behavioural flash device answering status polls
// Assumes: bench starts an operation by a pulse on go
// Notes:   fail keeps the operation running until the reset command
`timescale 1ns/1ps
`default_nettype none

module flash_dev_model (
  // flash pins
  input  wire logic        csN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic [15:0] dout,
  input  wire logic        doeN,
  output logic      [15:0] din,
  output logic             busyPullN,
  // scenario controls
  input  wire logic        go,
  input  wire logic [15:0] cnt,
  input  wire logic        fail,
  input  wire logic        erase,
  input  wire logic        expBit,
  input  wire logic [15:0] arr,
  input  wire logic        susp
);
  logic        busy = 1'b0;
  logic        t6   = 1'b0;
  logic        t2   = 1'b0;
  logic [15:0] left = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic        halt;
  logic        early;
  logic        pollBit;
  logic [15:0] cur;

  ////////////////////////////////////////////////////////////
  // an erase under suspend stands still; a program during suspend runs on
  assign halt    = susp & erase;
  // on the last busy read the poll bit already shows final data beside stale status
  assign early   = (left == 16'h0001) && !fail;
  // erase: 0 while running, 1 once done or suspended; program: complement until done
  assign pollBit = erase ? (susp | early) : (early ? expBit : ~expBit);
  // only the polled, unprotected selected sector is modelled; protected ones are skipped
  assign cur = busy ? {8'h00, pollBit, t6, fail, 1'b0, erase, t2, 2'b00} : arr;
  // released bus shows the inverse of the last word, never a stale copy
  assign din = (!csN && !oeN) ? cur : ~last;
  assign busyPullN = (busy && !halt) ? 1'b0 : 1'b1; // pull-up when released

  // status valid from the rising edge of go
  always @(posedge go) begin
    busy = 1'b1;
    left = cnt;
  end

  // each completed busy read inverts t6 unless halted and t2 only during erase, and counts down the work unless failed or halted
  always @(posedge oeN) if (!csN) begin
    last = cur;
    if (busy) begin
      if (!halt) t6 = ~t6;
      t2 = t2 ^ erase;
      if (!fail && !halt) left = left - 16'h0001;
      if (!fail && !halt && left == 16'h0000) busy = 1'b0;
    end
  end

  // reset command ends a failed operation
  always @(posedge weN) if (!csN && !doeN && dout == 16'h00F0) busy = 1'b0;
endmodule : flash_dev_model
`default_nettype wire

// file: flash_status_poller_tb_top.sv
// Purpose: self-checking bench of the flash status poller
// Assumes: flash_dev_model on the flash pins
// Notes:   random poll runs from a fixed seed plus corner cases
`timescale 1ns/1ps
`default_nettype none
`include "flash_poll_params.svh"

module flash_status_poller_tb_top;
  import flash_poll_pkg::*;
  logic                  clock, rst_n, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd, r;
  logic                  chipSelectN, outputStrobeN, writeStrobeN, flashDataOeN, readyBusyN;
  logic [`FP_ADDR_W-1:0] flashAddr;
  logic [`FP_DATA_W-1:0] flashDataOut, flashDataIn;
  logic                  go, fail, erase, expBit, susp;
  logic [15:0]           cnt, arr;
  int                    err_total = 0;
  int                    checks = 0;
  int                    seed = 32'hacdb_4fea;

  flash_status_poller u_dut (.clock, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .chipSelectN, .outputStrobeN, .writeStrobeN, .flashAddr, .flashDataOut,
    .flashDataOeN, .flashDataIn, .readyBusyN);
  flash_dev_model u_dev (.csN(chipSelectN), .oeN(outputStrobeN), .weN(writeStrobeN), .dout(flashDataOut),
    .doeN(flashDataOeN), .din(flashDataIn), .busyPullN(readyBusyN), .go, .cnt, .fail, .erase, .expBit, .arr,
    .susp);

  ////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [31:0] expSt(input logic f);
    return f ? 32'h0000_001A : 32'h0000_0016; // done, fail or pass, line released
  endfunction : expSt

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // start a device operation, poll it to the end, check the outcome
  task automatic run(input logic m, input logic e, input logic f, input logic [15:0] c, input logic [15:0] a,
                     input logic ab, input logic s);
    int n;
    n = 0;
    @(posedge clock);
    erase <= e;
    fail <= f;
    cnt <= c;
    susp <= s;
    expBit <= e | a[7];
    arr <= e ? (a | 16'h0080) : a;
    go <= 1'b1;
    apb(1'b1, `FP_REG_EXPECT, {31'h0, e | a[7]});
    go <= 1'b0;
    apb(1'b1, `FP_REG_ADDR, {16'h0000, a});
    apb(1'b1, `FP_REG_CTRL, {30'h0, m, 1'b0});
    apb(1'b1, `FP_REG_CTRL, {30'h0, m, 1'b1});
    if (ab) begin
      apb(1'b1, `FP_REG_CTRL, {29'h0, 1'b1, m, 1'b0});
      do apb(1'b0, `FP_REG_STATUS, 32'h0); while (rd[0] !== 1'b0 && ++n < 50);
      chk("abort status", rd & 32'h0000_0005, 32'h0);
      apb(1'b1, `FP_REG_CTRL, {30'h0, m, 1'b1});
    end
    n = 0;
    do begin
      apb(1'b0, `FP_REG_STATUS, 32'h0);
      if (n == 0) chk("busy line", {31'h0, rd[4]}, {31'h0, s & e});
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
    chk("final status", rd & 32'h0000_001F, expSt(f));
    if (e && !m) chk("sector toggle", {31'h0, rd[5]}, 32'h1);
    if (f) chk("timeout seen", rd & 32'h0000_00C0, 32'h0000_0080);
    if (!f) begin
      apb(1'b0, `FP_REG_DATA, 32'h0);
      if (s && e) chk("suspend word", rd & 32'h0000_FF88, 32'h0000_0088);
      else chk("array data", rd, {16'h0000, arr});
    end
    $display("test mode %0d erase %0d fail %0d abort %0d suspend %0d done", m, e, f, ab, s);
  endtask : run

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // watchdog against a hung poll
  initial begin
    repeat (80000) @(posedge clock);
    err_total++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, go, fail, erase, expBit, cnt, arr, susp} = '0;
    ce = 1'b1;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `FP_REG_STATUS, 32'h0);
    chk("status reset", rd, 32'h0000_0010);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset and decode done");
    run(1'b0, 1'b0, 1'b0, 16'h0003, 16'h5A3C, 1'b0, 1'b0);
    run(1'b0, 1'b1, 1'b0, 16'h0005, 16'h00C3, 1'b0, 1'b0);
    run(1'b1, 1'b0, 1'b0, 16'h0004, 16'h0081, 1'b0, 1'b0);
    run(1'b1, 1'b1, 1'b0, 16'h0006, 16'h0011, 1'b0, 1'b0);
    run(1'b0, 1'b0, 1'b1, 16'h0003, 16'h0000, 1'b0, 1'b0);
    run(1'b1, 1'b0, 1'b1, 16'h0003, 16'h0080, 1'b0, 1'b0);
    run(1'b0, 1'b0, 1'b0, 16'h003C, 16'h7E01, 1'b1, 1'b0);
    // protected program target: status for about one read, then array data
    run(1'b0, 1'b0, 1'b0, 16'h0001, 16'h1234, 1'b0, 1'b0);
    // erase suspended: toggle stands still, sector toggle goes on, line released
    run(1'b0, 1'b1, 1'b0, 16'h0004, 16'h0C30, 1'b0, 1'b1);
    // program during erase suspend toggles as usual
    run(1'b0, 1'b0, 1'b0, 16'h0004, 16'h2468, 1'b0, 1'b1);
    repeat (6) begin
      r = $random(seed);
      run(r[0], r[1], 1'b0, {12'h000, r[5:2]} + 16'h0003, r[31:16], 1'b0, 1'b0);
    end
    print_verdict();
  end
endmodule : flash_status_poller_tb_top
`default_nettype wire
